// file: include/sas_defs.vh
// constants for the successive-approximation converter sequencer
// Behaviour
// - bit5 picks negative reference pin or ground
// - bit4 picks positive reference pin or supply
// - port code marks thirteen pins analog/digital
// - reset port code 0000 or 0111 by option (code loads it only when POR_I is high in reset)
// - bit7 right-justifies result else left-justifies
// - acquisition codes give 20..0 clock periods
// - seven conversion clock sources selectable
// - code 111 selects dedicated rc clock
// - reset clears registers, disables, aborts conversion
// - completion loads result, clears busy, sets flag
// - reset leaves result registers untouched
// - nonzero acquisition samples then converts automatically
// - acquisition code 000 converts immediately
// - after conversion sampling of channel resumes
// - no status shows acquisition versus conversion
// - conversion takes eleven conversion clock periods
// - hold capacitor disconnected once conversion begins
// - two periods between conversion end and acquisition
// - sleep conversion only with rc clock
// - busy reads 1 converting, 0 idle
// - enable bit powers converter
// - channel field selects channels 0 to 12
// - clearing busy aborts, result keeps old value
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH
`define SAS_ADDR_W 3
`define SAS_A_CTRL0 3'h0
`define SAS_A_REFCFG 3'h1
`define SAS_A_TIMING 3'h2
`define SAS_A_RES_HI 3'h3
`define SAS_A_RES_LO 3'h4
`define SAS_A_FLAGS 3'h5
`define SAS_B_ENABLE 0
`define SAS_B_BUSY 1
`define SAS_B_CHAN_LO 2
`define SAS_B_CHAN_HI 5
`define SAS_B_NEGREF 5
`define SAS_B_POSREF 4
`define SAS_B_JUSTIFY 7
`define SAS_B_ACQ_LO 3
`define SAS_B_ACQ_HI 5
`define SAS_B_FLAG 0
`define SAS_B_IRQEN 1
`define SAS_PCFG_ALL_ANALOG 4'h0
`define SAS_PCFG_PB_DIGITAL 4'h7
`define SAS_TIMING_RST 8'h00
`define SAS_CONV_BITS 4'ha
`define SAS_CONV_TAD 5'h0b
`define SAS_GAP_TAD 5'h02
`define SAS_RC_DIV 8'hc8
`endif

// file: core/sas_sequencer.v
// converter sequencer: registers, conversion clock, acquisition and sar control
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.vh"
module sas_sequencer (
    input wire CORE_CLK_I,
    input wire SYS_RST_I,
    input wire POR_I,
    input wire PORT_ANALOG_DEFAULT_OPTION_I,
    input wire SLEEP_I,
    input wire [`SAS_ADDR_W-1:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire COMPARATOR_I,
    output reg [7:0] RDATA_O,
    output reg [3:0] CHANNEL_SELECT_O,
    output reg NEG_REF_SELECT_O,
    output reg POS_REF_SELECT_O,
    output reg [12:0] PIN_ANALOG_O,
    output reg SAMPLE_CONNECT_O,
    output reg [9:0] DAC_CODE_O,
    output reg CONVERTER_POWER_O,
    output reg IRQ_O
);
    localparam ST_IDLE = 4'h1;
    localparam ST_ACQ = 4'h2;
    localparam ST_CONV = 4'h4;
    localparam ST_GAP = 4'h8;

    reg [3:0] state;
    reg converter_enable;
    reg busy;
    reg [3:0] channel_select;
    reg neg_ref_select;
    reg pos_ref_select;
    reg [3:0] port_analog_config;
    reg [7:0] timing;
    reg [7:0] result_high_byte;
    reg [7:0] result_low_byte;
    reg conversion_done_flag;
    reg conversion_irq_enable;
    reg [7:0] div_cnt;
    reg [4:0] tad_cnt;
    reg [3:0] bit_idx;
    reg [9:0] sar;
    reg comp_s1;
    reg comp_s2;
    reg sleep_s1;
    reg sleep_s2;
    reg por_seen;

    wire [2:0] conv_clock_select = timing[2:0];
    wire [2:0] acquisition_time_select = timing[`SAS_B_ACQ_HI:`SAS_B_ACQ_LO];
    wire result_justify = timing[`SAS_B_JUSTIFY];
    wire use_rc = (conv_clock_select[1:0] == 2'h3);

    // oscillator periods per conversion period
    function [7:0] tad_div;
        input [2:0] code;
        begin
            case (code)
                3'h0: tad_div = 8'h02;
                3'h4: tad_div = 8'h04;
                3'h1: tad_div = 8'h08;
                3'h5: tad_div = 8'h10;
                3'h2: tad_div = 8'h20;
                3'h6: tad_div = 8'h40;
                default: tad_div = `SAS_RC_DIV;
            endcase
        end
    endfunction

    function [4:0] acq_periods;
        input [2:0] code;
        begin
            case (code)
                3'h7: acq_periods = 5'h14;
                3'h6: acq_periods = 5'h10;
                3'h5: acq_periods = 5'h0c;
                3'h4: acq_periods = 5'h08;
                3'h3: acq_periods = 5'h06;
                3'h2: acq_periods = 5'h04;
                3'h1: acq_periods = 5'h02;
                default: acq_periods = 5'h00;
            endcase
        end
    endfunction

    // pins AN0..AN12 analog mask for a port code
    function [12:0] analog_mask;
        input [3:0] code;
        begin
            case (code)
                4'h0, 4'h1, 4'h2: analog_mask = 13'h1fff;
                4'h3: analog_mask = 13'h0fff;
                4'h4: analog_mask = 13'h07ff;
                4'h5: analog_mask = 13'h03ff;
                4'h6: analog_mask = 13'h01ff;
                4'h7: analog_mask = 13'h00ff;
                4'h8: analog_mask = 13'h007f;
                4'h9: analog_mask = 13'h003f;
                4'ha: analog_mask = 13'h001f;
                4'hb: analog_mask = 13'h000f;
                4'hc: analog_mask = 13'h0007;
                4'hd: analog_mask = 13'h0003;
                4'he: analog_mask = 13'h0001;
                default: analog_mask = 13'h0000;
            endcase
        end
    endfunction

    // sleep stops the oscillator divisions; only the rc clock keeps ticking
    wire clk_runs = converter_enable & (use_rc | ~sleep_s2);
    wire [7:0] div_max = tad_div(conv_clock_select) - 8'h01;
    wire tad_tick = clk_runs & (div_cnt == div_max);
    wire wr_ctrl = WR_I & (ADDR_I == `SAS_A_CTRL0);
    wire busy_wr = WDATA_I[`SAS_B_BUSY];
    wire start = wr_ctrl & busy_wr & ~busy & converter_enable
                 & WDATA_I[`SAS_B_ENABLE] & (state != ST_GAP);
    wire abort = wr_ctrl & ~busy_wr & busy;
    wire [9:0] trial = sar | ({9'h000, 1'b1} << bit_idx);
    wire conv_last = tad_tick & (state == ST_CONV) & (tad_cnt == `SAS_CONV_TAD - 5'h01);

    // limitation: trial to decision takes three core cycles, so the 2x division decides on a stale compare
    always @(posedge CORE_CLK_I) begin
        comp_s1 <= COMPARATOR_I;
        comp_s2 <= comp_s1;
        sleep_s1 <= SLEEP_I;
        sleep_s2 <= sleep_s1;
    end

    always @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            div_cnt <= 8'h00;
        end else if (!clk_runs || tad_tick || state == ST_IDLE) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    always @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            tad_cnt <= 5'h00;
            bit_idx <= 4'h0;
            sar <= 10'h000;
        end else if (!converter_enable || abort) begin
            state <= abort ? ST_GAP : ST_IDLE;
            busy <= 1'b0;
            tad_cnt <= 5'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        busy <= 1'b1;
                        tad_cnt <= 5'h00;
                        sar <= 10'h000;
                        bit_idx <= `SAS_CONV_BITS - 4'h1;
                        state <= (acquisition_time_select == 3'h0) ? ST_CONV : ST_ACQ;
                    end
                end
                ST_ACQ: begin
                    if (tad_tick) begin
                        if (tad_cnt == acq_periods(acquisition_time_select) - 5'h01) begin
                            tad_cnt <= 5'h00;
                            state <= ST_CONV;
                        end else begin
                            tad_cnt <= tad_cnt + 5'h01;
                        end
                    end
                end
                ST_CONV: begin
                    if (tad_tick) begin
                        tad_cnt <= tad_cnt + 5'h01;
                        // first period settles the hold, then one bit per period
                        if (tad_cnt != 5'h00) begin
                            if (!comp_s2) begin
                                sar <= trial & ~({9'h000, 1'b1} << bit_idx);
                            end else begin
                                sar <= trial;
                            end
                            bit_idx <= bit_idx - 4'h1;
                        end
                        if (conv_last) begin
                            busy <= 1'b0;
                            tad_cnt <= 5'h00;
                            state <= ST_GAP;
                        end
                    end
                end
                ST_GAP: begin
                    if (tad_tick) begin
                        if (tad_cnt == `SAS_GAP_TAD - 5'h01) begin
                            tad_cnt <= 5'h00;
                            state <= ST_IDLE;
                        end else begin
                            tad_cnt <= tad_cnt + 5'h01;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // the trial value of the last bit with its comparator decision
    wire [9:0] final_code = comp_s2 ? trial : (trial & ~({9'h000, 1'b1} << bit_idx));

    // result kept out of reset so power-up contents stay undefined
    always @(posedge CORE_CLK_I) begin
        if (WR_I && ADDR_I == `SAS_A_RES_HI) begin
            result_high_byte <= WDATA_I;
        end else if (conv_last && converter_enable && !abort) begin
            result_high_byte <= result_justify ? {6'h00, final_code[9:8]} : final_code[9:2];
        end
        if (WR_I && ADDR_I == `SAS_A_RES_LO) begin
            result_low_byte <= WDATA_I;
        end else if (conv_last && converter_enable && !abort) begin
            result_low_byte <= result_justify ? final_code[7:0] : {final_code[1:0], 6'h00};
        end
    end

    // strap caught on the clock after power-on release
    always @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            converter_enable <= 1'b0;
            channel_select <= 4'h0;
            neg_ref_select <= 1'b0;
            pos_ref_select <= 1'b0;
            timing <= `SAS_TIMING_RST;
            conversion_done_flag <= 1'b0;
            conversion_irq_enable <= 1'b0;
            por_seen <= POR_I;
        end else begin
            por_seen <= 1'b0;
            if (por_seen) begin
                port_analog_config <= PORT_ANALOG_DEFAULT_OPTION_I ?
                    `SAS_PCFG_ALL_ANALOG : `SAS_PCFG_PB_DIGITAL;
            end else if (WR_I && ADDR_I == `SAS_A_REFCFG) begin
                port_analog_config <= WDATA_I[3:0];
            end
            if (wr_ctrl) begin
                converter_enable <= WDATA_I[`SAS_B_ENABLE];
                channel_select <= WDATA_I[`SAS_B_CHAN_HI:`SAS_B_CHAN_LO];
            end
            if (WR_I && ADDR_I == `SAS_A_REFCFG) begin
                neg_ref_select <= WDATA_I[`SAS_B_NEGREF];
                pos_ref_select <= WDATA_I[`SAS_B_POSREF];
            end
            if (WR_I && ADDR_I == `SAS_A_TIMING) begin
                timing <= WDATA_I & 8'hbf;
            end
            if (WR_I && ADDR_I == `SAS_A_FLAGS) begin
                conversion_irq_enable <= WDATA_I[`SAS_B_IRQEN];
            end
            // completion wins over a software clear in the same cycle
            if (conv_last && converter_enable && !abort) begin
                conversion_done_flag <= 1'b1;
            end else if (WR_I && ADDR_I == `SAS_A_FLAGS) begin
                conversion_done_flag <= WDATA_I[`SAS_B_FLAG];
            end
        end
    end

    always @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            RDATA_O <= 8'h00;
            CHANNEL_SELECT_O <= 4'h0;
            NEG_REF_SELECT_O <= 1'b0;
            POS_REF_SELECT_O <= 1'b0;
            PIN_ANALOG_O <= 13'h0000;
            SAMPLE_CONNECT_O <= 1'b0;
            DAC_CODE_O <= 10'h000;
            CONVERTER_POWER_O <= 1'b0;
            IRQ_O <= 1'b0;
        end else begin
            CHANNEL_SELECT_O <= channel_select;
            NEG_REF_SELECT_O <= neg_ref_select;
            POS_REF_SELECT_O <= pos_ref_select;
            PIN_ANALOG_O <= analog_mask(port_analog_config);
            // hold opens in conversion, in the gap and while the converter is disabled; sampling otherwise
            SAMPLE_CONNECT_O <= converter_enable & (state == ST_IDLE || state == ST_ACQ);
            DAC_CODE_O <= (state == ST_CONV) ? trial : 10'h000;
            CONVERTER_POWER_O <= converter_enable;
            IRQ_O <= conversion_done_flag & conversion_irq_enable;
            RDATA_O <= 8'h00;
            if (RD_I) begin
                case (ADDR_I)
                    `SAS_A_CTRL0: RDATA_O <= {2'h0, channel_select, busy, converter_enable};
                    `SAS_A_REFCFG: RDATA_O <= {2'h0, neg_ref_select, pos_ref_select, port_analog_config};
                    `SAS_A_TIMING: RDATA_O <= timing;
                    `SAS_A_RES_HI: RDATA_O <= result_high_byte;
                    `SAS_A_RES_LO: RDATA_O <= result_low_byte;
                    `SAS_A_FLAGS: RDATA_O <= {6'h00, conversion_irq_enable, conversion_done_flag};
                    default: RDATA_O <= 8'h00;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/sas_analog_model.sv
// behavioural analog front end: track/hold capacitor and comparator
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model (
    input wire logic clk_i,
    input wire logic [9:0] level_i,
    input wire logic sample_i,
    input wire logic [9:0] dac_i,
    output logic cmp_o
);
    logic [9:0] held = 10'h000;
    // cap only tracks while connected, so late input changes must not leak in
    always @(posedge clk_i) begin
        if (sample_i) begin
            held <= level_i;
        end
    end
    assign cmp_o = held >= dac_i;
endmodule
`default_nettype wire

// file: bench/sas_sequencer_asserts.sv
// port checker for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.vh"
module sas_sequencer_chk (
    input wire CORE_CLK_I,
    input wire SYS_RST_I,
    input wire [`SAS_ADDR_W-1:0] ADDR_I,
    input wire [7:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire [7:0] RDATA_O,
    input wire NEG_REF_SELECT_O,
    input wire POS_REF_SELECT_O,
    input wire [12:0] PIN_ANALOG_O,
    input wire SAMPLE_CONNECT_O,
    input wire [9:0] DAC_CODE_O,
    input wire CONVERTER_POWER_O,
    input wire IRQ_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire wr_ref = WR_I && ADDR_I == `SAS_A_REFCFG;
    property p_neg_ref; wr_ref |-> ##2 NEG_REF_SELECT_O == $past(WDATA_I[5], 2); endproperty
    property p_pos_ref; wr_ref |-> ##2 POS_REF_SELECT_O == $past(WDATA_I[4], 2); endproperty
    property p_pins_analog; wr_ref && WDATA_I[3:0] == 4'h0 |-> ##2 PIN_ANALOG_O == 13'h1fff; endproperty
    property p_pins_digital; wr_ref && WDATA_I[3:0] == 4'hf |-> ##2 PIN_ANALOG_O == 13'h0000; endproperty
    property p_power;
        WR_I && ADDR_I == `SAS_A_CTRL0 |-> ##2 CONVERTER_POWER_O == $past(WDATA_I[0], 2);
    endproperty
    property p_hold_open; DAC_CODE_O != 10'h000 |-> !SAMPLE_CONNECT_O; endproperty
    property p_msb_first; $past(DAC_CODE_O) == 10'h000 && DAC_CODE_O != 10'h000 |-> DAC_CODE_O == 10'h200; endproperty
    property p_irq_masked; WR_I && ADDR_I == `SAS_A_FLAGS && !WDATA_I[1] |-> ##2 !IRQ_O; endproperty
    property p_rdata_idle; !RD_I |=> RDATA_O == 8'h00; endproperty
    property p_reset_quiet;
        disable iff (1'b0) SYS_RST_I [*3] |-> !CONVERTER_POWER_O && !IRQ_O && DAC_CODE_O == 10'h000 && !SAMPLE_CONNECT_O;
    endproperty
    a_neg_ref: assert property (p_neg_ref) else $error("negative reference select wrong");
    a_pos_ref: assert property (p_pos_ref) else $error("positive reference select wrong");
    a_pins_analog: assert property (p_pins_analog) else $error("pins not all analog");
    a_pins_digital: assert property (p_pins_digital) else $error("pins not all digital");
    a_power: assert property (p_power) else $error("converter power does not follow enable");
    a_hold_open: assert property (p_hold_open) else $error("hold cap connected during conversion");
    a_msb_first: assert property (p_msb_first) else $error("first trial code is not midscale");
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while disabled");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
    c_conv: cover property (DAC_CODE_O == 10'h200);
    c_irq: cover property ($rose(IRQ_O));
    c_resample: cover property ($rose(SAMPLE_CONNECT_O));
endmodule
bind sas_sequencer sas_sequencer_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .NEG_REF_SELECT_O(NEG_REF_SELECT_O),
    .POS_REF_SELECT_O(POS_REF_SELECT_O), .PIN_ANALOG_O(PIN_ANALOG_O), .SAMPLE_CONNECT_O(SAMPLE_CONNECT_O),
    .DAC_CODE_O(DAC_CODE_O), .CONVERTER_POWER_O(CONVERTER_POWER_O), .IRQ_O(IRQ_O));
`default_nettype wire

// file: bench/test_sas_sequencer.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sas_defs.vh"
module test_sas_sequencer;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1, por = 1'b1, pad_opt = 1'b0, sleep = 1'b0, wr = 1'b0, rd = 1'b0, ok;
    logic [`SAS_ADDR_W-1:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, d, hi, lo;
    logic [9:0] level = 10'h000;
    wire cmp, negref, posref, sample, power, irq;
    wire [7:0] rdata;
    wire [3:0] chan;
    wire [12:0] pins;
    wire [9:0] dac;
    int n_mismatch = 0, checks_done = 0, cyc = 0, t0, div;
    localparam int LIMIT = 60000;
    int acq_t[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    logic [2:0] clk_c[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int div_t[8] = '{2, 4, 8, 16, 32, 64, `SAS_RC_DIV, `SAS_RC_DIV};
    logic [9:0] vals[8] = '{10'h3ff, 10'h000, 10'h155, 10'h2aa, 10'h001, 10'h200, 10'h1ff, 10'h37c};
    logic [12:0] pin_t[16] = '{13'h1fff, 13'h1fff, 13'h1fff, 13'h0fff, 13'h07ff, 13'h03ff, 13'h01ff, 13'h00ff,
        13'h007f, 13'h003f, 13'h001f, 13'h000f, 13'h0007, 13'h0003, 13'h0001, 13'h0000};
    sas_sequencer dut (.CORE_CLK_I(core_clk), .SYS_RST_I(sys_rst), .POR_I(por),
        .PORT_ANALOG_DEFAULT_OPTION_I(pad_opt), .SLEEP_I(sleep), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .COMPARATOR_I(cmp), .RDATA_O(rdata), .CHANNEL_SELECT_O(chan), .NEG_REF_SELECT_O(negref),
        .POS_REF_SELECT_O(posref), .PIN_ANALOG_O(pins), .SAMPLE_CONNECT_O(sample), .DAC_CODE_O(dac),
        .CONVERTER_POWER_O(power), .IRQ_O(irq));
    sas_analog_model fe (.clk_i(core_clk), .level_i(level), .sample_i(sample), .dac_i(dac), .cmp_o(cmp));
    always #2.5 core_clk = ~core_clk;
    task automatic complete_run();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // a hang in a polling loop ends here instead of running forever
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic rdc(input string what, input logic [2:0] a, input logic [7:0] exp);
        rd_reg(a);
        check(what, d, exp);
    endtask
    task automatic do_reset(input logic p, input logic opt);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        por <= p;
        pad_opt <= opt;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        por <= 1'b0;
    endtask
    // polls busy; the bound keeps a stuck busy bit from eating the whole run
    task automatic wait_idle();
        for (int k = 0; k < 8000; k++) begin
            rd_reg(`SAS_A_CTRL0);
            if (d[`SAS_B_BUSY] === 1'b0) break;
        end
    endtask
    initial begin
        do_reset(1'b1, 1'b0);
        rdc("refcfg_por0", `SAS_A_REFCFG, 8'h07);
        rdc("timing_rst", `SAS_A_TIMING, `SAS_TIMING_RST);
        rdc("ctrl_rst", `SAS_A_CTRL0, 8'h00);
        do_reset(1'b1, 1'b1);
        rdc("refcfg_por1", `SAS_A_REFCFG, 8'h00);
        wr_reg(`SAS_A_TIMING, 8'hff);
        rdc("timing_b6", `SAS_A_TIMING, 8'hbf);
        rdc("unmapped", 3'h6, 8'h00);
        for (int c = 0; c < 16; c++) begin
            wr_reg(`SAS_A_REFCFG, {2'b00, c[1:0], c[3:0]});
            repeat (2) @(posedge core_clk);
            #1;
            check("pins", pins, pin_t[c]);
            check("negref", negref, c[1]);
            check("posref", posref, c[0]);
        end
        wr_reg(`SAS_A_REFCFG, 8'h00);
        wr_reg(`SAS_A_CTRL0, 8'h03);
        rdc("start_refused", `SAS_A_CTRL0, 8'h01);
        check("power", power, 1'b1);
        wr_reg(`SAS_A_FLAGS, 8'h01);
        wr_reg(`SAS_A_FLAGS, 8'h02);
        for (int i = 0; i < 8; i++) begin
            div = div_t[i];
            level <= vals[i];
            wr_reg(`SAS_A_TIMING, {i[0], 1'b0, i[2:0], clk_c[i]});
            wr_reg(`SAS_A_CTRL0, {2'b00, i[3:0], 2'b11});
            t0 = cyc;
            wait_idle();
            ok = (cyc - t0 >= (acq_t[i] + 11) * div - 2) && (cyc - t0 <= (acq_t[i] + 12) * div + 6);
            check("conv_time", ok, 1'b1);
            check("irq", irq, 1'b1);
            hi = i[0] ? {6'h00, vals[i][9:8]} : vals[i][9:2];
            lo = i[0] ? vals[i][7:0] : {vals[i][1:0], 6'h00};
            rdc("res_hi", `SAS_A_RES_HI, hi);
            rdc("res_lo", `SAS_A_RES_LO, lo);
            rdc("flags", `SAS_A_FLAGS, 8'h03);
            check("chan", chan, i[3:0]);
            if (div >= 64) begin
                wr_reg(`SAS_A_CTRL0, {2'b00, i[3:0], 2'b11});
                rdc("gap_refused", `SAS_A_CTRL0, {2'b00, i[3:0], 2'b01});
            end
            wr_reg(`SAS_A_FLAGS, 8'h02);
            repeat (2 * div + 4) @(posedge core_clk);
            #1;
            check("resample", sample, 1'b1);
            check("irq_clr", irq, 1'b0);
        end
        wr_reg(`SAS_A_TIMING, 8'h06);
        level <= 10'h0aa;
        wr_reg(`SAS_A_CTRL0, 8'h03);
        repeat (300) @(posedge core_clk);
        wr_reg(`SAS_A_CTRL0, 8'h01);
        rdc("abort_busy", `SAS_A_CTRL0, 8'h01);
        rdc("abort_hi", `SAS_A_RES_HI, hi);
        rdc("abort_lo", `SAS_A_RES_LO, lo);
        repeat (140) @(posedge core_clk);
        // fastest division is too quick for the synced comparator, so sleep uses the next one
        wr_reg(`SAS_A_TIMING, 8'h04);
        sleep <= 1'b1;
        repeat (3) @(posedge core_clk);
        wr_reg(`SAS_A_CTRL0, 8'h03);
        repeat (100) @(posedge core_clk);
        rdc("sleep_hold", `SAS_A_CTRL0, 8'h03);
        @(posedge core_clk);
        sleep <= 1'b0;
        wait_idle();
        rdc("sleep_done", `SAS_A_CTRL0, 8'h01);
        repeat (8) @(posedge core_clk);
        wr_reg(`SAS_A_CTRL0, 8'h03);
        repeat (8) @(posedge core_clk);
        do_reset(1'b0, 1'b1);
        rdc("rst_ctrl", `SAS_A_CTRL0, 8'h00);
        check("rst_power", power, 1'b0);
        rdc("rst_res_hi", `SAS_A_RES_HI, 8'h2a);
        rdc("rst_res_lo", `SAS_A_RES_LO, 8'h80);
        complete_run();
    end
endmodule
`default_nettype wire
